/* voice_store_serial_command_port.sv */
// Serial command port: decode, operation sequencing, settings and status
`timescale 1ns/1ns
// Behaviour
// - Sample on rising clock, drive on falling
// - Select falling edge starts a new frame
// - Frame is opcode byte then 16-bit field
// - Interrupt on end-of-message or overflow termination
// - Next complete frame clears pending interrupt
// - Status shifts out while command shifts in
// - Cleared run bit ends current operation, except on wake
// - Commands act only at select release
// - Skip runs 1600x faster, stops past marker
// - Load path or mix settings, X ignored
// - Play from address in field
// - Play from current address until marker/overflow
// - Record from address in field
// - Record from current address until overflow
// - Skip to message end, else overflow
// - Stop; or stop and enter standby
// - Status read returns overflow and end flags
// - Wake delay before operational commands
// - Wake, wait, load settings, play address
// - Path settings applied with mix load
module voice_store_serial_command_port #(
    parameter int WAKE_CYCLES = voice_port_pkg::WAKE_CYCLES,
    parameter int ROW_CYCLES = voice_port_pkg::ROW_CYCLES,
    parameter logic [15:0] ARRAY_LAST = voice_port_pkg::ARRAY_LAST
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Serial link pins
    input wire logic ss_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Storage array
    input wire logic eom_marker_i,
    output logic [15:0] row_addr_o,
    // Operation status
    output logic powered_o,
    output logic play_o,
    output logic record_o,
    output logic cue_o,
    output logic int_o,
    // Applied settings
    output logic [15:0] path_settings_o,
    output logic [15:0] mix_rate_settings_o
);

    localparam int CUE_CYCLES = ROW_CYCLES / voice_port_pkg::CUE_SPEEDUP;

    // Elaboration checks
    if (CUE_CYCLES < 1) begin : g_bad_row
        $error("ROW_CYCLES too small for the skip rate");
    end
    if (WAKE_CYCLES < 1) begin : g_bad_wake
        $error("WAKE_CYCLES must be at least one");
    end

    voice_port_pkg::op_state_t state_ff;
    voice_port_pkg::op_state_t nxt_state;
    logic [2:0] link_sync;
    logic [15:0] addr_ff;
    logic [15:0] nxt_addr;
    logic [31:0] wake_cnt_ff;
    logic [31:0] rate_cnt_ff;
    logic [31:0] rate_last;
    logic [15:0] path_pend_ff;
    logic [15:0] path_ff;
    logic [15:0] mix_ff;
    logic eom_flag_ff;
    logic ovf_flag_ff;
    logic ev_eom;
    logic ev_ovf;
    logic row_tick;
    logic moving;
    logic cmd_valid;
    logic cmd_ok;
    logic [7:0] op;
    logic [15:0] field;
    logic [voice_port_pkg::FRAME_BITS-1:0] status_word;

    // Pin synchronisers
    pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({ss_n_i, sclk_i, mosi_i}),
        .sync_o(link_sync)
    );

    // Status: overflow, end flag, row pointer, padding
    always_comb begin
        status_word = '0;
        status_word[voice_port_pkg::ST_OVF_POS] = ovf_flag_ff;
        status_word[voice_port_pkg::ST_EOM_POS] = eom_flag_ff;
        status_word[voice_port_pkg::ST_ADDR_LSB +: 16] = addr_ff;
    end

    // Frame shifter
    frame_shifter u_shift (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ss_n_i(link_sync[2]),
        .sclk_i(link_sync[1]),
        .mosi_i(link_sync[0]),
        .status_i(status_word),
        .miso_o(miso_o),
        .miso_oe_o(miso_oe_o),
        .frame_done_o(cmd_valid),
        .opcode_o(op),
        .field_o(field)
    );

    // Commands other than wake and sleep need a settled powered device
    assign cmd_ok = (state_ff != voice_port_pkg::ST_OFF) && (state_ff != voice_port_pkg::ST_WAKING);
    assign moving = (state_ff == voice_port_pkg::ST_PLAY) || (state_ff == voice_port_pkg::ST_RECORD)
        || (state_ff == voice_port_pkg::ST_CUE);
    assign rate_last = (state_ff == voice_port_pkg::ST_CUE) ? 32'(CUE_CYCLES - 1) : 32'(ROW_CYCLES - 1);
    assign row_tick = moving && (rate_cnt_ff == rate_last);

    // Next state, address and terminating events
    always_comb begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        ev_eom = 1'b0;
        ev_ovf = 1'b0;
        if (cmd_valid) begin
            if (op == voice_port_pkg::OP_HALT_SLEEP) begin
                nxt_state = voice_port_pkg::ST_OFF;
            end else if (op == voice_port_pkg::OP_WAKE) begin
                if (state_ff == voice_port_pkg::ST_OFF) begin
                    nxt_state = voice_port_pkg::ST_WAKING;
                end
            end else if (cmd_ok) begin
                case (op)
                    voice_port_pkg::OP_PLAY_AT: begin
                        nxt_addr = field;
                        nxt_state = voice_port_pkg::ST_PLAY;
                    end
                    voice_port_pkg::OP_PLAY_CUR: begin
                        nxt_state = voice_port_pkg::ST_PLAY;
                    end
                    voice_port_pkg::OP_REC_AT: begin
                        nxt_addr = field;
                        nxt_state = voice_port_pkg::ST_RECORD;
                    end
                    voice_port_pkg::OP_REC_CUR: begin
                        nxt_state = voice_port_pkg::ST_RECORD;
                    end
                    voice_port_pkg::OP_SKIP: begin
                        nxt_state = voice_port_pkg::ST_CUE;
                    end
                    default: begin
                        if (!op[voice_port_pkg::RUN_POS]) begin
                            nxt_state = voice_port_pkg::ST_READY;
                        end
                    end
                endcase
            end
        end else if (state_ff == voice_port_pkg::ST_WAKING) begin
            if (wake_cnt_ff == 32'(WAKE_CYCLES - 1)) begin
                nxt_state = voice_port_pkg::ST_READY;
            end
        end else if (row_tick) begin
            if ((state_ff != voice_port_pkg::ST_RECORD) && eom_marker_i) begin
                ev_eom = 1'b1;
                nxt_state = voice_port_pkg::ST_READY;
                if (state_ff == voice_port_pkg::ST_CUE) begin
                    nxt_addr = addr_ff + 16'h0001;
                end
            end else if (addr_ff == ARRAY_LAST) begin
                ev_ovf = 1'b1;
                nxt_state = voice_port_pkg::ST_READY;
            end else begin
                nxt_addr = addr_ff + 16'h0001;
            end
        end
    end

    // State and address registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= voice_port_pkg::ST_OFF;
            addr_ff <= voice_port_pkg::ADDR_RST;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
        end
    end

    // Wake delay counter
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_cnt_ff <= '0;
        end else if (state_ff != voice_port_pkg::ST_WAKING) begin
            wake_cnt_ff <= '0;
        end else begin
            wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
        end
    end

    // Row rate counter, restarted by every state change
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rate_cnt_ff <= '0;
        end else if (!moving || (nxt_state != state_ff) || row_tick) begin
            rate_cnt_ff <= '0;
        end else begin
            rate_cnt_ff <= rate_cnt_ff + 32'h0000_0001;
        end
    end

    // Settings: path held pending until mix load
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            path_pend_ff <= voice_port_pkg::SETTINGS_RST;
            path_ff <= voice_port_pkg::SETTINGS_RST;
            mix_ff <= voice_port_pkg::SETTINGS_RST;
        end else if (cmd_valid && cmd_ok) begin
            if ((op & voice_port_pkg::OP_CFG_MASK) == voice_port_pkg::OP_LOAD_PATH) begin
                path_pend_ff <= field;
            end
            if ((op & voice_port_pkg::OP_CFG_MASK) == voice_port_pkg::OP_LOAD_MIX) begin
                mix_ff <= field;
                path_ff <= path_pend_ff;
            end
        end
    end

    // Sticky flags: event sets, complete frame clears, set wins
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            eom_flag_ff <= 1'b0;
            ovf_flag_ff <= 1'b0;
        end else begin
            eom_flag_ff <= ev_eom || (eom_flag_ff && !cmd_valid);
            ovf_flag_ff <= ev_ovf || (ovf_flag_ff && !cmd_valid);
        end
    end

    // Outputs
    assign int_o = eom_flag_ff || ovf_flag_ff;
    assign row_addr_o = addr_ff;
    assign powered_o = (state_ff != voice_port_pkg::ST_OFF);
    assign play_o = (state_ff == voice_port_pkg::ST_PLAY);
    assign record_o = (state_ff == voice_port_pkg::ST_RECORD);
    assign cue_o = (state_ff == voice_port_pkg::ST_CUE);
    assign path_settings_o = path_ff;
    assign mix_rate_settings_o = mix_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_ready_cmd(logic [7:0] code);
        cmd_valid && cmd_ok && op == code;
    endsequence

    sequence s_marker_hit;
        row_tick && eom_marker_i && (play_o || cue_o) && !cmd_valid;
    endsequence

    play_at_start_a: assert property (s_ready_cmd(voice_port_pkg::OP_PLAY_AT) |=> play_o && row_addr_o == $past(field))
        else $error("Play at address did not start at the field address");
    rec_at_start_a: assert property (s_ready_cmd(voice_port_pkg::OP_REC_AT) |=> record_o && row_addr_o == $past(field))
        else $error("Record at address did not start at the field address");
    stop_ends_a: assert property (s_ready_cmd(voice_port_pkg::OP_STOP) |=> state_ff == voice_port_pkg::ST_READY)
        else $error("Stop did not end the operation");
    sleep_cmd_a: assert property (cmd_valid && op == voice_port_pkg::OP_HALT_SLEEP |=> !powered_o ##1 !powered_o)
        else $error("Halt and sleep did not power down");
    marker_irq_a: assert property (s_marker_hit |=> int_o && !play_o && !cue_o)
        else $error("End marker did not stop and interrupt");
    irq_clear_a: assert property (int_o && cmd_valid && !ev_eom && !ev_ovf |=> !int_o)
        else $error("Complete frame did not clear the interrupt");
    cfg_apply_a: assert property (s_ready_cmd(voice_port_pkg::OP_LOAD_MIX) |=> path_settings_o == $past(path_pend_ff)
        && mix_rate_settings_o == $past(field))
        else $error("Settings not applied together at mix load");
    wake_hold_a: assert property (state_ff == voice_port_pkg::ST_WAKING && !cmd_valid
        && wake_cnt_ff != 32'(WAKE_CYCLES - 1) |=> state_ff == voice_port_pkg::ST_WAKING)
        else $error("Wake delay ended early");
    wake_block_a: assert property (cmd_valid && !cmd_ok && op == voice_port_pkg::OP_PLAY_AT |=> !play_o)
        else $error("Operation accepted during wake delay");
    cue_advance_a: assert property (s_marker_hit ##0 cue_o |=> row_addr_o == $past(row_addr_o) + 16'h0001)
        else $error("Skip did not point past the marker");
    overflow_a: assert property (row_tick && record_o && row_addr_o == ARRAY_LAST && !cmd_valid
        |=> ovf_flag_ff && !record_o)
        else $error("Record did not stop at array end");
    rec_marker_a: assert property (row_tick && record_o && eom_marker_i && row_addr_o != ARRAY_LAST && !cmd_valid
        |=> record_o && row_addr_o == $past(row_addr_o) + 16'h0001)
        else $error("Record stopped on an end marker");
    run_clear_a: assert property (cmd_valid && cmd_ok && !op[voice_port_pkg::RUN_POS]
        && op != voice_port_pkg::OP_WAKE |=> !play_o && !record_o && !cue_o)
        else $error("Cleared run bit left an operation running");
    play_cur_a: assert property (s_ready_cmd(voice_port_pkg::OP_PLAY_CUR)
        |=> play_o && row_addr_o == $past(row_addr_o))
        else $error("Play from current address moved the address");
    skip_rate_a: assert property (cue_o |-> rate_cnt_ff < 32'(CUE_CYCLES))
        else $error("Skip stepped slower than the skip rate");

endmodule

/* voice_port_pkg.sv */
// Shared constants for the voice store serial command port
package voice_port_pkg;

    // Clock and timing
    localparam int CLK_MHZ = 250;
    localparam int WAKE_DELAY_US = 25000;
    localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;
    localparam int ROW_PERIOD_US = 200000;
    localparam int ROW_CYCLES = ROW_PERIOD_US * CLK_MHZ;
    localparam int CUE_SPEEDUP = 1600;

    // Frame layout
    localparam int OP_W = 8;
    localparam int FIELD_W = 16;
    localparam int FRAME_BITS = OP_W + FIELD_W;
    localparam int CNT_W = 5;
    localparam int RUN_POS = 7;
    localparam int ST_OVF_POS = 23;
    localparam int ST_EOM_POS = 22;
    localparam int ST_ADDR_LSB = 6;

    // Opcodes
    localparam logic [7:0] OP_WAKE = 8'h60;
    localparam logic [7:0] OP_LOAD_PATH = 8'h42;
    localparam logic [7:0] OP_LOAD_MIX = 8'h44;
    localparam logic [7:0] OP_CFG_MASK = 8'hdf;
    localparam logic [7:0] OP_PLAY_AT = 8'he0;
    localparam logic [7:0] OP_PLAY_CUR = 8'hf0;
    localparam logic [7:0] OP_REC_AT = 8'ha0;
    localparam logic [7:0] OP_REC_CUR = 8'hb0;
    localparam logic [7:0] OP_SKIP = 8'hf8;
    localparam logic [7:0] OP_STOP = 8'h70;
    localparam logic [7:0] OP_HALT_SLEEP = 8'h50;

    // Storage array and reset values
    localparam logic [15:0] ARRAY_LAST = 16'h04af;
    localparam logic [15:0] SETTINGS_RST = 16'h0000;
    localparam logic [15:0] ADDR_RST = 16'h0000;

    // Operating states
    typedef enum logic [2:0] {ST_OFF, ST_WAKING, ST_READY, ST_PLAY, ST_RECORD, ST_CUE} op_state_t;

endpackage

/* pin_sync.sv */
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Meta stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

/* frame_shifter.sv */
// Serial frame shifter: bit capture, status shift-out, frame completion
`timescale 1ns/1ns
module frame_shifter (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Synchronised link levels
    input wire logic ss_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    // Status to shift out
    input wire logic [voice_port_pkg::FRAME_BITS-1:0] status_i,
    // Serial data out
    output logic miso_o,
    output logic miso_oe_o,
    // Received frame
    output logic frame_done_o,
    output logic [voice_port_pkg::OP_W-1:0] opcode_o,
    output logic [voice_port_pkg::FIELD_W-1:0] field_o
);

    localparam int FB = voice_port_pkg::FRAME_BITS;
    localparam int CW = voice_port_pkg::CNT_W;

    logic ss_prev_ff;
    logic sclk_prev_ff;
    logic [CW-1:0] bits_ff;
    logic [FB-1:0] rx_ff;
    logic [FB-1:0] tx_ff;
    logic miso_ff;
    logic done_ff;
    logic ss_fall;
    logic ss_rise;
    logic sclk_rise;
    logic sclk_fall;

    // Edge detection on synchronised levels
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ss_prev_ff <= 1'b1;
            sclk_prev_ff <= 1'b1;
        end else begin
            ss_prev_ff <= ss_n_i;
            sclk_prev_ff <= sclk_i;
        end
    end

    assign ss_fall = ss_prev_ff && !ss_n_i;
    assign ss_rise = !ss_prev_ff && ss_n_i;
    assign sclk_rise = !sclk_prev_ff && sclk_i && !ss_n_i;
    assign sclk_fall = sclk_prev_ff && !sclk_i && !ss_n_i;

    // Receive side: capture on rising serial clock
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_ff <= '0;
            bits_ff <= '0;
        end else if (ss_fall) begin
            bits_ff <= '0;
        end else if (sclk_rise) begin
            rx_ff <= {rx_ff[FB-2:0], mosi_i};
            if (bits_ff != '1) begin
                bits_ff <= bits_ff + CW'(1);
            end
        end
    end

    // Transmit side: status loaded at frame start, shifted on falling clock
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_ff <= '0;
            miso_ff <= 1'b0;
        end else if (ss_fall) begin
            tx_ff <= status_i;
            miso_ff <= status_i[FB-1];
        end else if (sclk_fall) begin
            tx_ff <= {tx_ff[FB-2:0], 1'b0};
            miso_ff <= tx_ff[FB-2];
        end
    end

    // Frame accepted only on select release with exact bit count
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= ss_rise && (bits_ff == CW'(FB));
        end
    end

    assign frame_done_o = done_ff;
    assign opcode_o = rx_ff[FB-1:voice_port_pkg::FIELD_W];
    assign field_o = rx_ff[voice_port_pkg::FIELD_W-1:0];
    assign miso_o = miso_ff;
    assign miso_oe_o = !ss_n_i;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    miso_on_fall_a: assert property ($changed(miso_o) |-> $past(sclk_fall) || $past(ss_fall))
        else $error("MISO changed outside a falling clock or frame start");
    done_on_release_a: assert property (frame_done_o |-> $past(ss_rise) && $past(bits_ff) == CW'(FB))
        else $error("Frame completed without select release and 24 bits");
    rx_on_rise_a: assert property ($changed(rx_ff) |-> $past(sclk_rise))
        else $error("Receive register moved outside a rising clock");

endmodule

/* host_link_model.sv */
// Host-side link master model: select, serial clock, data out, status capture
`timescale 1ns/1ns
module host_link_model #(
    parameter int HALF_NS = 32
) (
    // Link to the port
    output logic ss_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    logic last_bit;

    // Idle link: select high, clock parked low
    initial begin
        ss_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b1;
        last_bit = 1'b0;
    end

    // One frame, MSB first, opcode byte then field; clock runs only inside the frame
    task automatic xfer(input logic [23:0] frame, input int nbits, output logic [23:0] rx);
        rx = 24'h000000;
        ss_n_o = 1'b0;
        #(HALF_NS);
        for (int i = 0; i < nbits; i++) begin
            sclk_o = 1'b0;
            mosi_o = frame[23 - i];
            last_bit = frame[23 - i];
            #(HALF_NS);
            sclk_o = 1'b1;
            rx[23 - i] = miso_oe_i ? miso_i : 1'bx;
            #(HALF_NS);
        end
        sclk_o = 1'b0;
        #(HALF_NS);
        ss_n_o = 1'b1;
        mosi_o = ~last_bit;
        #(2 * HALF_NS);
    endtask
endmodule

/* tb_voice_store_serial_command_port.sv */
// Self-checking bench for the voice store serial command port
`timescale 1ns/1ns
module tb_voice_store_serial_command_port;
    localparam int WAKE_N = 1000;
    localparam int ROW_N = 3200;
    localparam logic [15:0] LAST_ROW = 16'h0004;

    // Clock, reset and pins
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ss_n, sclk, mosi, miso, miso_oe, eom_marker;
    logic powered, play, record, cue, irq;
    logic [15:0] row_addr, path_set, mix_set;
    // Reference model and bookkeeping
    int m_st;
    logic m_pow, m_ovf, m_eom, m_waking;
    logic [15:0] m_addr, m_path, m_mix, m_pend;
    int marker_row = -1;
    int n_mismatch = 0;
    int num_checks = 0;

    // Clock and array marker for the current row
    always #2 ref_clk_i = ~ref_clk_i;
    assign eom_marker = (row_addr == marker_row[15:0]);

    voice_store_serial_command_port #(
        .WAKE_CYCLES(WAKE_N),
        .ROW_CYCLES(ROW_N),
        .ARRAY_LAST(LAST_ROW)
    ) uut (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .ss_n_i(ss_n),
        .sclk_i(sclk),
        .mosi_i(mosi),
        .miso_o(miso),
        .miso_oe_o(miso_oe),
        .eom_marker_i(eom_marker),
        .row_addr_o(row_addr),
        .powered_o(powered),
        .play_o(play),
        .record_o(record),
        .cue_o(cue),
        .int_o(irq),
        .path_settings_o(path_set),
        .mix_rate_settings_o(mix_set)
    );

    host_link_model host (
        .ss_n_o(ss_n),
        .sclk_o(sclk),
        .mosi_o(mosi),
        .miso_i(miso),
        .miso_oe_i(miso_oe)
    );

    // Compare one value and count it
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Compare every output except the serial data pins against the model
    task automatic cmp_all();
        check("state pins", {m_pow, m_st == 1, m_st == 2, m_st == 3, m_ovf | m_eom},
              {powered, play, record, cue, irq});
        check("row address", m_addr, row_addr);
        check("path settings", m_path, path_set);
        check("mix settings", m_mix, mix_set);
    endtask

    // Model effect of one complete frame
    task automatic apply(input logic [7:0] op, input logic [15:0] f);
        m_ovf = 1'b0;
        m_eom = 1'b0;
        if (!m_pow) begin
            m_waking = (op == 8'h60);
            if (op == 8'h60) m_pow = 1'b1;
        end else if (m_waking) begin
            if (op == 8'h50) m_pow = 1'b0;
        end else if ((op & 8'hdf) == 8'h42) begin
            m_pend = f;
            m_st = 0;
        end else if ((op & 8'hdf) == 8'h44) begin
            m_path = m_pend;
            m_mix = f;
            m_st = 0;
        end else begin
            if (op == 8'he0 || op == 8'ha0) m_addr = f;
            case (op)
                8'he0, 8'hf0: m_st = 1;
                8'ha0, 8'hb0: m_st = 2;
                8'hf8: m_st = 3;
                8'h70, 8'h50: m_st = 0;
                default: ;
            endcase
            if (op == 8'h50) m_pow = 1'b0;
        end
    endtask

    // Send a frame, check shifted-out status, then the settled outputs
    task automatic do_frame(input logic [7:0] op, input logic [15:0] f, input int nbits, input bit quiet);
        logic [23:0] rx;
        logic [23:0] exp_st;
        exp_st = {m_ovf, m_eom, m_addr, 6'h00};
        @(posedge ref_clk_i);
        #1;
        host.xfer({op, f}, nbits, rx);
        if (nbits == 24) check("status out", exp_st, rx);
        repeat (10) @(posedge ref_clk_i);
        #1;
        if (nbits == 24) apply(op, f);
        if (!quiet) cmp_all();
    endtask

    // Wait for an ending event, bounded, then compare
    task automatic wait_irq(input int limit, input logic ovf, input logic [15:0] addr);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < limit) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        // A limit that runs out is a mismatch
        if (irq !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] interrupt wait expected 1 seen %b", irq);
        end
        repeat (2) @(posedge ref_clk_i);
        #1;
        m_st = 0;
        m_ovf = ovf;
        m_eom = !ovf;
        m_addr = addr;
        cmp_all();
    endtask

    task automatic tend(input string name);
        $display("Test %s done", name);
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hung wait
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [15:0] p;
        logic [15:0] x;
        m_st = 0;
        m_pow = 1'b0;
        m_ovf = 1'b0;
        m_eom = 1'b0;
        m_waking = 1'b0;
        m_addr = 16'h0000;
        m_path = 16'h0000;
        m_mix = 16'h0000;
        m_pend = 16'h0000;
        void'($urandom(26));
        repeat (12) @(posedge ref_clk_i);
        #1;
        reset_n_i = 1'b1;
        cmp_all();
        // Asleep: play ignored; then wake and wait out the delay
        do_frame(8'he0, 16'h0002, 24, 1'b0);
        do_frame(8'h60, 16'h0000, 24, 1'b0);
        do_frame(8'he0, 16'h0002, 24, 1'b0);
        repeat (WAKE_N + 10) @(posedge ref_clk_i);
        m_waking = 1'b0;
        tend("wake");
        // First settings held until the second is loaded, both spellings of each load
        p = 16'($urandom);
        x = 16'($urandom);
        do_frame(8'h62, p, 24, 1'b0);
        do_frame(8'h44, x, 24, 1'b0);
        do_frame(8'h42, x, 24, 1'b0);
        do_frame(8'h64, p, 24, 1'b0);
        tend("settings");
        // Play from row 2 up to the marker on row 3, then from the current row
        marker_row = 3;
        do_frame(8'he0, 16'h0002, 24, 1'b0);
        wait_irq(3 * ROW_N, 1'b0, 16'h0003);
        do_frame(8'hf0, 16'($urandom), 24, 1'b0);
        wait_irq(2 * ROW_N, 1'b0, 16'h0003);
        do_frame(8'h70, 16'h0000, 16, 1'b0);
        tend("playback");
        // Skip past the marker, then skip into the end of the array
        do_frame(8'hf8, 16'h0000, 24, 1'b1);
        wait_irq(8, 1'b0, 16'h0004);
        do_frame(8'hf8, 16'h0000, 24, 1'b1);
        wait_irq(8, 1'b1, 16'h0004);
        tend("skip");
        // Record stopped early, then run on to overflow past an ignored marker
        marker_row = 2;
        do_frame(8'ha0, 16'h0001, 24, 1'b0);
        do_frame(8'h70, 16'h0000, 24, 1'b0);
        do_frame(8'hb0, 16'h0000, 24, 1'b0);
        wait_irq(5 * ROW_N, 1'b1, LAST_ROW);
        do_frame(8'h70, 16'h0000, 24, 1'b0);
        tend("record");
        // Sleep, then a command that must be ignored
        do_frame(8'h50, 16'h0000, 24, 1'b0);
        do_frame(8'hb0, 16'h0000, 24, 1'b0);
        tend("sleep");
        stop_test();
    end
endmodule
